// ===== rtl/card_status_interrupt_control.sv
// Interrupt steering, card type, card reset and status change latch of one socket.
// Assumes the status change enables and the acknowledge mode come from neighbouring logic.
module card_status_interrupt_control #(
   parameter int NUM_IRQ = 16
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire card_status_pkg::reg_req_t req,
   output logic [7:0] rdata,
   input wire card_status_pkg::card_pins_t pins,
   input wire logic func_irq_b,
   input wire logic [3:0] csc_enable,
   input wire logic explicit_ack,
   input wire logic [3:0] csc_irq_sel,
   output logic card_reset_b,
   output logic io_card,
   output logic ring_indicate,
   output logic csc_int,
   output logic [NUM_IRQ-1:0] irq_out
);
   if (NUM_IRQ < 16) begin : g_chk
      $error("NUM_IRQ must cover a 4-bit select");
   end

   logic [7:0] igc_reg;
   logic [3:0] csc_reg;
   logic [3:0] csc_next;
   logic [3:0] set_vec;
   logic [3:0] vis;
   logic cd_prev_reg;
   logic rdy_prev_reg;
   logic stsc_prev_reg;
   logic seated;
   logic ring_en;
   logic is_io;
   logic rd_csc;

   function automatic logic [NUM_IRQ-1:0] irq_decode(input logic [3:0] sel, input logic act);
      logic [NUM_IRQ-1:0] v;
      v = '0;
      if (act && sel != card_status_pkg::IRQ_NONE) begin
         v[sel] = 1'b1;
      end
      return v;
   endfunction : irq_decode

   assign seated = !pins.cd1_b && !pins.cd2_b;
   assign is_io = igc_reg[card_status_pkg::TYPE_BIT];
   assign ring_en = igc_reg[card_status_pkg::RING_BIT] && is_io;
   assign rd_csc = req.rd && req.addr == card_status_pkg::CSC_OFFSET;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         igc_reg <= card_status_pkg::IGC_RESET;
      end else if (req.wr && req.addr == card_status_pkg::IGC_OFFSET) begin
         igc_reg <= req.wdata & card_status_pkg::IGC_WMASK;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cd_prev_reg <= 1'b0;
         rdy_prev_reg <= 1'b0;
         stsc_prev_reg <= 1'b1;
      end else begin
         cd_prev_reg <= seated;
         rdy_prev_reg <= pins.ready;
         stsc_prev_reg <= pins.bvd1;
      end
   end

   always_comb begin
      set_vec = '0;
      set_vec[card_status_pkg::CD_BIT] = seated != cd_prev_reg;
      set_vec[card_status_pkg::RDY_BIT] = pins.ready && !rdy_prev_reg;
      set_vec[card_status_pkg::WARN_BIT] = !is_io && pins.bvd1 && !pins.bvd2;
      if (is_io) begin
         set_vec[card_status_pkg::DEAD_BIT] = !ring_en && !pins.bvd1 && stsc_prev_reg;
      end else begin
         set_vec[card_status_pkg::DEAD_BIT] = !pins.bvd1;
      end
      set_vec = set_vec & csc_enable;
   end

   always_comb begin
      csc_next = csc_reg;
      if (rd_csc && !explicit_ack) begin
         csc_next = '0;
      end
      if (req.wr && req.addr == card_status_pkg::CSC_OFFSET) begin
         csc_next = csc_next & ~req.wdata[3:0];
      end
      // Set beats clear so no event is lost
      csc_next = csc_next | set_vec;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         csc_reg <= card_status_pkg::CSC_RESET[3:0];
      end else begin
         csc_reg <= csc_next;
      end
   end

   always_comb begin
      vis = csc_reg & csc_enable;
      if (is_io) begin
         vis[card_status_pkg::WARN_BIT] = 1'b0;
      end
      if (ring_en) begin
         vis[card_status_pkg::DEAD_BIT] = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdata <= '0;
      end else if (req.rd) begin
         unique case (req.addr)
            card_status_pkg::IGC_OFFSET: rdata <= igc_reg;
            card_status_pkg::CSC_OFFSET: rdata <= {4'h0, vis};
            default: rdata <= '0;
         endcase
      end else begin
         rdata <= '0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         csc_int <= 1'b0;
         card_reset_b <= 1'b0;
         io_card <= 1'b0;
         ring_indicate <= 1'b0;
         irq_out <= '0;
      end else begin
         csc_int <= |(csc_next & csc_enable);
         card_reset_b <= igc_reg[card_status_pkg::RESET_BIT];
         io_card <= is_io;
         ring_indicate <= ring_en && !pins.bvd1;
         irq_out <= irq_decode(igc_reg[card_status_pkg::IRQ_LSB +: card_status_pkg::IRQ_W],
                              is_io && !func_irq_b)
                  | irq_decode(csc_irq_sel, |(csc_next & csc_enable));
      end
   end

   property p_warn_io;
      @(posedge clk) disable iff (!rst_b) (req.rd && req.addr == card_status_pkg::CSC_OFFSET
         && is_io) |=> !rdata[card_status_pkg::WARN_BIT];
   endproperty
   a_warn_io: assert property (p_warn_io) else $error("warning bit read set for I/O");

   property p_upper_zero;
      @(posedge clk) disable iff (!rst_b) rd_csc |=> rdata[7:4] == 4'h0;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("reserved bits nonzero");

   property p_rd_clear;
      @(posedge clk) disable iff (!rst_b) (rd_csc && !explicit_ack && set_vec == 4'h0)
         |=> csc_reg == 4'h0;
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("read did not clear");

   property p_int_level;
      @(posedge clk) disable iff (!rst_b) ##1 csc_int == $past(|(csc_next & csc_enable));
   endproperty
   a_int_level: assert property (p_int_level) else $error("interrupt not level");

   property p_rdy_set;
      @(posedge clk) disable iff (!rst_b) (pins.ready && !rdy_prev_reg
         && csc_enable[card_status_pkg::RDY_BIT]) |=> csc_reg[card_status_pkg::RDY_BIT];
   endproperty
   a_rdy_set: assert property (p_rdy_set) else $error("ready edge lost");

   property p_disabled_zero;
      @(posedge clk) disable iff (!rst_b) (rd_csc && !csc_enable[card_status_pkg::CD_BIT])
         |=> !rdata[card_status_pkg::CD_BIT];
   endproperty
   a_disabled_zero: assert property (p_disabled_zero) else $error("disabled bit read");

   property p_card_reset;
      @(posedge clk) disable iff (!rst_b) ##1 card_reset_b ==
         $past(igc_reg[card_status_pkg::RESET_BIT]);
   endproperty
   a_card_reset: assert property (p_card_reset) else $error("card reset mismatch");

   property p_w1c;
      @(posedge clk) disable iff (!rst_b) (req.wr && req.addr == card_status_pkg::CSC_OFFSET
         && req.wdata[card_status_pkg::CD_BIT] && !set_vec[card_status_pkg::CD_BIT])
         |=> !csc_reg[card_status_pkg::CD_BIT];
   endproperty
   a_w1c: assert property (p_w1c) else $error("write one did not clear");

   property p_ring_zero;
      @(posedge clk) disable iff (!rst_b) (rd_csc && ring_en) |=> !rdata[card_status_pkg::DEAD_BIT];
   endproperty
   a_ring_zero: assert property (p_ring_zero) else $error("bit 0 set under ring");
endmodule : card_status_interrupt_control

// ===== rtl/card_status_pkg.sv
// Constants and carriers for the socket interrupt, general control and status change block.
// Assumes a byte-wide register port on the host clock, card pins already synchronous.
package card_status_pkg;
   localparam logic [7:0] IGC_OFFSET = 8'h03;
   localparam logic [7:0] CSC_OFFSET = 8'h04;
   localparam logic [7:0] IGC_RESET = 8'h00;
   localparam logic [7:0] IGC_WMASK = 8'hEF;
   localparam logic [7:0] CSC_RESET = 8'h00;
   localparam int RING_BIT = 7;
   localparam int RESET_BIT = 6;
   localparam int TYPE_BIT = 5;
   localparam int IRQ_LSB = 0;
   localparam int IRQ_W = 4;
   localparam int CD_BIT = 3;
   localparam int RDY_BIT = 2;
   localparam int WARN_BIT = 1;
   localparam int DEAD_BIT = 0;
   localparam logic [3:0] IRQ_NONE = 4'h0;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic cd1_b;
      logic cd2_b;
      logic ready;
      logic bvd1;
      logic bvd2;
   } card_pins_t;
endpackage : card_status_pkg

// ===== dv/card_model.sv
// Behavioural card in the socket: detect pins, ready and battery lines.
// Assumes the bench sets the wanted card levels just after clock edges.
module card_model (
   input wire logic seated,
   input wire logic rdy,
   input wire logic b1,
   input wire logic b2,
   input wire logic card_reset_b,
   output card_status_pkg::card_pins_t pins
);
   timeunit 1ns;
   timeprecision 1ns;
   // Empty socket floats to pull-ups; a card in reset reports busy
   always_comb begin
      pins.cd1_b = ~seated;
      pins.cd2_b = ~seated;
      pins.ready = seated ? (rdy & card_reset_b) : 1'b1;
      pins.bvd1 = seated ? b1 : 1'b1;
      pins.bvd2 = seated ? b2 : 1'b1;
   end
endmodule : card_model

// ===== dv/test_card_status_interrupt_control.sv
// Self-checking bench for the socket control and status change block.
// Assumes one 100 MHz clock and the one-cycle register port of the design.
module test_card_status_interrupt_control;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_b, func_irq_b, explicit_ack, seated, rdy, b1, b2;
   logic [3:0] csc_enable, csc_irq_sel;
   card_status_pkg::reg_req_t req;
   card_status_pkg::card_pins_t pins;
   logic [7:0] rdata;
   logic card_reset_b, io_card, ring_indicate, csc_int;
   logic [15:0] irq_out;
   int failures, cmp_count, cyc;
   card_status_interrupt_control #(.NUM_IRQ(16)) dut_u (.clk(clk), .rst_b(rst_b), .req(req),
      .rdata(rdata), .pins(pins), .func_irq_b(func_irq_b), .csc_enable(csc_enable),
      .explicit_ack(explicit_ack), .csc_irq_sel(csc_irq_sel), .card_reset_b(card_reset_b),
      .io_card(io_card), .ring_indicate(ring_indicate), .csc_int(csc_int), .irq_out(irq_out));
   card_model card_u (.seated(seated), .rdy(rdy), .b1(b1), .b2(b2),
      .card_reset_b(card_reset_b), .pins(pins));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic stop_test();
      if (failures == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : idle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk) req <= '0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk) req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk) req <= '0;
      #1 chk(rdata, exp);
   endtask : rd
   // Hang guard, well above the roughly 80 cycles needed
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         failures++;
         stop_test();
      end
   end
   initial begin
      rst_b = 1'b0; req = '0; func_irq_b = 1'b1; explicit_ack = 1'b1; csc_enable = 4'h0;
      csc_irq_sel = 4'h5; seated = 1'b0; rdy = 1'b1; b1 = 1'b1; b2 = 1'b1;
      failures = 0; cmp_count = 0; cyc = 0;
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      idle(1);
      chk({7'h00, card_reset_b}, 8'h00);
      rd(8'h03, 8'h00);
      rd(8'h04, 8'h00);
      csc_enable <= 4'hF;
      wr(8'h03, 8'hFF);
      rd(8'h03, 8'hEF);
      chk({6'h00, io_card, card_reset_b}, 8'h03);
      func_irq_b <= 1'b0;
      idle(3);
      chk(irq_out[15:8], 8'h80);
      wr(8'h03, 8'hE0);
      idle(3);
      chk(irq_out[15:8], 8'h00);
      func_irq_b <= 1'b1;
      seated <= 1'b1;
      idle(3);
      b1 <= 1'b0;
      idle(3);
      chk({7'h00, ring_indicate}, 8'h01);
      chk({csc_int, irq_out[6:0]}, 8'hA0);
      rd(8'h04, 8'h08);
      wr(8'h04, 8'h08);
      idle(3);
      chk({7'h00, csc_int}, 8'h00);
      wr(8'h03, 8'h60);
      b1 <= 1'b1;
      b2 <= 1'b0;
      idle(3);
      b1 <= 1'b0;
      idle(3);
      rd(8'h04, 8'h01);
      wr(8'h04, 8'h00);
      rd(8'h04, 8'h01);
      explicit_ack <= 1'b0;
      rdy <= 1'b0;
      idle(3);
      rdy <= 1'b1;
      idle(3);
      rd(8'h04, 8'h05);
      idle(2);
      chk({7'h00, csc_int}, 8'h00);
      rd(8'h04, 8'h00);
      wr(8'h03, 8'h40);
      b1 <= 1'b1;
      idle(3);
      rd(8'h04, 8'h02);
      b1 <= 1'b0;
      idle(3);
      rd(8'h04, 8'h03);
      csc_enable <= 4'h0;
      idle(2);
      rd(8'h04, 8'h00);
      stop_test();
   end
endmodule : test_card_status_interrupt_control
